// ### rtl/gpp_consts.vh
/*
 Constants of the general purpose parallel port: register selects,
 access operations, reset values and widths. Definitions only; included
 by the port and its synchroniser.
*/
`ifndef GPP_CONSTS_VH
`define GPP_CONSTS_VH

// Port width
`define GPP_WIDTH        16

// Register select codes
`define GPP_SEL_W        4
`define GPP_SEL_DIR      4'h0
`define GPP_SEL_LAT      4'h1
`define GPP_SEL_LEVEL    4'h2
`define GPP_SEL_ODRAIN   4'h3
`define GPP_SEL_ANALOG   4'h4
`define GPP_SEL_CNEN     4'h5
`define GPP_SEL_CNFLAG   4'h6
`define GPP_SEL_PULLUP   4'h7
`define GPP_SEL_PULLDN   4'h8

// Write operations: base, clear, set, invert companion
`define GPP_OP_W         2
`define GPP_OP_BASE      2'h0
`define GPP_OP_CLR       2'h1
`define GPP_OP_SET       2'h2
`define GPP_OP_INV       2'h3

// Reset values
`define GPP_RST_DIR      16'hffff
`define GPP_RST_ANALOG   16'hffff
`define GPP_RST_ZERO     16'h0000

// Synchroniser depth
`define GPP_SYNC_STAGES  2

`endif

// ### rtl/gpp_port.v
/*
 General purpose parallel I/O port, 16 pins: direction, output latch,
 pin level read, open drain, analog select, weak pulls, change notice.
 Assumes a simple one-cycle register access port driven by core logic
 on core_clk, and pad cells outside that resolve pinOut/pinOe and pulls.
*/
// Function
// - Direction bit one makes the pin an input, zero an output driver.
// - After reset every pin is an input, all direction bits set.
// - Latch reads return stored latch; latch writes update the driving latch.
// - Pin level reads return sampled pins; writes there update the latch.
// - Open drain bit makes a driven one release the pin, low only.
// - Analog input needs analog and direction set; digital input needs analog clear.
// - Analog select resets to all ones, pins start in analog mode.
// - Output with analog set still drives the digital level.
// - Pin level read returns zero for analog input pins.
// - Change detection works in sleep with clocks stopped to wake the core.
// - Each pin has a change notice enable allowing its interrupt request.
// - Change flag tells whether pin changed since its last level read.
// - Each pin has separate weak pull-up and pull-down enables.
// - An active multiplexed peripheral owns the pin over general I/O unless its analog bit is set.
// - Clear, set, invert companions modify only bits written as one.
// - Companion reads return zero; only the base shows the result.
`timescale 1ns/1ns
`include "gpp_consts.vh"

module gpp_port (
    core_clk,
    sys_rst,
    regWrEn,
    regRdEn,
    regSel,
    regOp,
    regWrData,
    regRdData,
    changeNoticeOn,
    periphEn,
    periphOe,
    periphOut,
    periphIn,
    pinIn,
    pinOut,
    pinOe,
    analogInSel,
    pullUpOn,
    pullDownOn,
    changeIrq,
    sleepWake
);
    input  wire                    core_clk;
    input  wire                    sys_rst;
    input  wire                    regWrEn;
    input  wire                    regRdEn;
    input  wire [`GPP_SEL_W-1:0]   regSel;
    input  wire [`GPP_OP_W-1:0]    regOp;
    input  wire [`GPP_WIDTH-1:0]   regWrData;
    output wire [`GPP_WIDTH-1:0]   regRdData;
    input  wire                    changeNoticeOn;
    input  wire [`GPP_WIDTH-1:0]   periphEn;
    input  wire [`GPP_WIDTH-1:0]   periphOe;
    input  wire [`GPP_WIDTH-1:0]   periphOut;
    output wire [`GPP_WIDTH-1:0]   periphIn;
    input  wire [`GPP_WIDTH-1:0]   pinIn;
    output wire [`GPP_WIDTH-1:0]   pinOut;
    output wire [`GPP_WIDTH-1:0]   pinOe;
    output wire [`GPP_WIDTH-1:0]   analogInSel;
    output wire [`GPP_WIDTH-1:0]   pullUpOn;
    output wire [`GPP_WIDTH-1:0]   pullDownOn;
    output wire                    changeIrq;
    output wire                    sleepWake;

    reg  [`GPP_WIDTH-1:0] pinDirection_ff;
    reg  [`GPP_WIDTH-1:0] outputLatch_ff;
    reg  [`GPP_WIDTH-1:0] openDrainSelect_ff;
    reg  [`GPP_WIDTH-1:0] analogSelect_ff;
    reg  [`GPP_WIDTH-1:0] changeNoticeEnable_ff;
    reg  [`GPP_WIDTH-1:0] weakPullupEnable_ff;
    reg  [`GPP_WIDTH-1:0] weakPulldownEnable_ff;
    reg  [`GPP_WIDTH-1:0] changeNoticeFlags_ff;
    reg  [`GPP_WIDTH-1:0] levelRef_ff;
    reg  [`GPP_WIDTH-1:0] rdData_ff;
    reg  [`GPP_WIDTH-1:0] nxt_changeNoticeFlags;
    reg  [`GPP_WIDTH-1:0] nxt_rdData;
    wire [`GPP_WIDTH-1:0] pinSync;
    wire [`GPP_WIDTH-1:0] pinLevel;
    wire [`GPP_WIDTH-1:0] changeSeen;
    wire                  isBase;
    wire                  levelRead;

    // Base write, or clear/set/invert only where data bits are one
    function [`GPP_WIDTH-1:0] applyOp;
        input [`GPP_WIDTH-1:0] cur;
        input [`GPP_OP_W-1:0]  op;
        input [`GPP_WIDTH-1:0] d;
        begin
            case (op)
                `GPP_OP_CLR: applyOp = cur & ~d;
                `GPP_OP_SET: applyOp = cur | d;
                `GPP_OP_INV: applyOp = cur ^ d;
                default:     applyOp = d;
            endcase
        end
    endfunction

    // Pins resynchronised before any clocked use
    gpp_sync2 u_sync (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .asyncIn  (pinIn),
        .syncOut  (pinSync)
    );

    // Analog inputs read back as zero
    assign pinLevel = pinSync & ~(analogSelect_ff & pinDirection_ff);
    assign isBase    = (regOp == `GPP_OP_BASE);
    assign levelRead = regRdEn && isBase && (regSel == `GPP_SEL_LEVEL);

    // Configuration registers with companion operations
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pinDirection_ff       <= `GPP_RST_DIR;
            outputLatch_ff        <= `GPP_RST_ZERO;
            openDrainSelect_ff    <= `GPP_RST_ZERO;
            analogSelect_ff       <= `GPP_RST_ANALOG;
            changeNoticeEnable_ff <= `GPP_RST_ZERO;
            weakPullupEnable_ff   <= `GPP_RST_ZERO;
            weakPulldownEnable_ff <= `GPP_RST_ZERO;
        end else if (regWrEn) begin
            case (regSel)
                `GPP_SEL_DIR:
                    pinDirection_ff <= applyOp(pinDirection_ff, regOp, regWrData);
                `GPP_SEL_LAT, `GPP_SEL_LEVEL:
                    outputLatch_ff <= applyOp(outputLatch_ff, regOp, regWrData);
                `GPP_SEL_ODRAIN:
                    openDrainSelect_ff <= applyOp(openDrainSelect_ff, regOp, regWrData);
                `GPP_SEL_ANALOG:
                    analogSelect_ff <= applyOp(analogSelect_ff, regOp, regWrData);
                `GPP_SEL_CNEN:
                    changeNoticeEnable_ff <= applyOp(changeNoticeEnable_ff, regOp,
                        regWrData);
                `GPP_SEL_PULLUP:
                    weakPullupEnable_ff <= applyOp(weakPullupEnable_ff, regOp, regWrData);
                `GPP_SEL_PULLDN:
                    weakPulldownEnable_ff <= applyOp(weakPulldownEnable_ff, regOp,
                        regWrData);
                default: begin
                end
            endcase
        end
    end

    // Change since last level read; a new change beats the read's clear
    assign changeSeen = (pinLevel ^ levelRef_ff) & {`GPP_WIDTH{changeNoticeOn}};
    always @* begin
        nxt_changeNoticeFlags = changeNoticeFlags_ff;
        if (levelRead) begin
            nxt_changeNoticeFlags = `GPP_RST_ZERO;
        end
        nxt_changeNoticeFlags = nxt_changeNoticeFlags | changeSeen;
    end

    // Reference follows the pins; flags hold the history between reads
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            levelRef_ff          <= `GPP_RST_ZERO;
            changeNoticeFlags_ff <= `GPP_RST_ZERO;
        end else begin
            levelRef_ff          <= pinLevel;
            changeNoticeFlags_ff <= nxt_changeNoticeFlags;
        end
    end

    // Read mux; companion selects read as zero
    always @* begin
        nxt_rdData = `GPP_RST_ZERO;
        if (isBase) begin
            case (regSel)
                `GPP_SEL_DIR:    nxt_rdData = pinDirection_ff;
                `GPP_SEL_LAT:    nxt_rdData = outputLatch_ff;
                `GPP_SEL_LEVEL:  nxt_rdData = pinLevel;
                `GPP_SEL_ODRAIN: nxt_rdData = openDrainSelect_ff;
                `GPP_SEL_ANALOG: nxt_rdData = analogSelect_ff;
                `GPP_SEL_CNEN:   nxt_rdData = changeNoticeEnable_ff;
                `GPP_SEL_CNFLAG: nxt_rdData = changeNoticeFlags_ff;
                `GPP_SEL_PULLUP: nxt_rdData = weakPullupEnable_ff;
                `GPP_SEL_PULLDN: nxt_rdData = weakPulldownEnable_ff;
                default:         nxt_rdData = `GPP_RST_ZERO;
            endcase
        end
    end

    // Read data registered, held until the next read
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rdData_ff <= `GPP_RST_ZERO;
        end else if (regRdEn) begin
            rdData_ff <= nxt_rdData;
        end
    end

    assign regRdData = rdData_ff;

    // Per-pin output driver and ownership
    genvar i;
    generate
        for (i = 0; i < `GPP_WIDTH; i = i + 1) begin : g_pin
            wire periphOwns;
            wire gpioDrive;
            assign periphOwns = periphEn[i] & ~analogSelect_ff[i];
            assign gpioDrive  = ~pinDirection_ff[i]
                              & ~(openDrainSelect_ff[i] & outputLatch_ff[i]);
            assign pinOe[i]   = periphOwns ? periphOe[i] : gpioDrive;
            assign pinOut[i]  = periphOwns ? periphOut[i]
                              : (outputLatch_ff[i] & ~openDrainSelect_ff[i]);
            assign periphIn[i]    = pinSync[i] & ~analogSelect_ff[i];
            assign analogInSel[i] = analogSelect_ff[i] & pinDirection_ff[i];
        end
    endgenerate

    assign pullUpOn   = weakPullupEnable_ff;
    assign pullDownOn = weakPulldownEnable_ff;

    // Interrupt request from enabled flags
    assign changeIrq = |(changeNoticeFlags_ff & changeNoticeEnable_ff);

    // Clockless wake: raw pins against the last seen levels
    assign sleepWake = changeNoticeOn
                     & |((pinIn ^ levelRef_ff) & changeNoticeEnable_ff
                         & ~(analogSelect_ff & pinDirection_ff));

endmodule // gpp_port

// ### rtl/gpp_sync2.v
/*
 Two flip-flop synchroniser for a vector of pin inputs.
 Assumes each bit is asynchronous to core_clk and may be sampled
 independently of its neighbours.
*/
`timescale 1ns/1ns
`include "gpp_consts.vh"

module gpp_sync2 (
    core_clk,
    sys_rst,
    asyncIn,
    syncOut
);
    input  wire                    core_clk;
    input  wire                    sys_rst;
    input  wire [`GPP_WIDTH-1:0]   asyncIn;
    output wire [`GPP_WIDTH-1:0]   syncOut;

    reg [`GPP_WIDTH-1:0] stage1_ff;
    reg [`GPP_WIDTH-1:0] stage2_ff;

    // First stage feeds only the second
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            stage1_ff <= `GPP_RST_ZERO;
            stage2_ff <= `GPP_RST_ZERO;
        end else begin
            stage1_ff <= asyncIn;
            stage2_ff <= stage1_ff;
        end
    end

    assign syncOut = stage2_ff;

endmodule // gpp_sync2

// ### verif/gpp_pin_model.sv
/* Outside world of the port pins: pad resolution and an external driver.
   Assumes the bench drives extDrv/extOe and the port drives pinOut/pinOe. */
`timescale 1ns/1ns
module gpp_pin_model (
    input  wire        core_clk,
    input  wire [15:0] pinOut,
    input  wire [15:0] pinOe,
    input  wire [15:0] pullUpOn,
    input  wire [15:0] pullDownOn,
    input  wire [15:0] extDrv,
    input  wire [15:0] extOe,
    output wire [15:0] pinIn
);
    reg [15:0] floatPat_ff = 16'h5a5a;
    // Released pin with no pull wanders every cycle
    always @(posedge core_clk) begin
        floatPat_ff <= ~floatPat_ff;
    end
    // Port driver first, then the outside device, then the weak pulls
    assign pinIn = (pinOe & pinOut) | (~pinOe & extOe & extDrv)
        | (~pinOe & ~extOe & (pullUpOn | (~pullDownOn & floatPat_ff)));
endmodule // gpp_pin_model

// ### verif/gpp_port_checker.sv
/* Assertions on the port's register and pad behaviour.
   Assumes it is bound to gpp_port and sees only its ports. */
`timescale 1ns/1ns
`include "gpp_consts.vh"
module gpp_port_checker (
    input wire                  core_clk,
    input wire                  sys_rst,
    input wire                  regWrEn,
    input wire                  regRdEn,
    input wire [3:0]            regSel,
    input wire [1:0]            regOp,
    input wire [`GPP_WIDTH-1:0] regWrData,
    input wire [`GPP_WIDTH-1:0] regRdData,
    input wire                  changeNoticeOn,
    input wire [`GPP_WIDTH-1:0] pinOe,
    input wire [`GPP_WIDTH-1:0] analogInSel,
    input wire [`GPP_WIDTH-1:0] pullUpOn,
    input wire [`GPP_WIDTH-1:0] pullDownOn,
    input wire                  changeIrq
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    // Reset state, register paths, analog pad drive and interrupt causes
    rst_state_a: assert property (disable iff (1'b0)
        sys_rst |-> pinOe == 0 && analogInSel == 16'hffff && !changeIrq) else $error("reset state");
    latch_back_a: assert property (regWrEn && regSel inside {1, 2} && regOp == 0
        ##1 regRdEn && !regWrEn && regSel == 1 && regOp == 0 |=> regRdData == $past(regWrData, 2))
        else $error("latch readback");
    comp_read_a: assert property (regRdEn && regOp != 0 |=> regRdData == 0)
        else $error("companion read");
    analog_zero_a: assert property (regRdEn && regSel == 2 && regOp == 0
        |=> (regRdData & $past(analogInSel)) == 0) else $error("analog pin read");
    analog_nodrv_a: assert property ((pinOe & analogInSel) == 0)
        else $error("analog pin driven");
    pull_base_a: assert property (regWrEn && regSel == 7 && regOp == 0
        |=> pullUpOn == $past(regWrData)) else $error("pull-up write");
    pull_set_a: assert property (regWrEn && regSel == 8 && regOp == 2
        |=> pullDownOn == ($past(pullDownOn) | $past(regWrData))) else $error("set write");
    pull_clr_a: assert property (regWrEn && regSel == 7 && regOp == 1
        |=> pullUpOn == ($past(pullUpOn) & ~$past(regWrData))) else $error("clear write");
    pull_inv_a: assert property (regWrEn && regSel == 8 && regOp == 3
        |=> pullDownOn == ($past(pullDownOn) ^ $past(regWrData))) else $error("invert write");
    irq_rise_a: assert property ($rose(changeIrq)
        |-> $past(changeNoticeOn) || $past(regWrEn)) else $error("irq without cause");
    irq_fall_a: assert property ($fell(changeIrq)
        |-> $past(regRdEn && regSel == 2) || $past(regWrEn)) else $error("irq dropped");
endmodule // gpp_port_checker
bind gpp_port gpp_port_checker chk (.core_clk(core_clk), .sys_rst(sys_rst),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regSel(regSel), .regOp(regOp),
    .regWrData(regWrData), .regRdData(regRdData), .changeNoticeOn(changeNoticeOn),
    .pinOe(pinOe), .analogInSel(analogInSel), .pullUpOn(pullUpOn),
    .pullDownOn(pullDownOn), .changeIrq(changeIrq));

// ### verif/gpp_port_test.sv
/* Self-checking bench for the parallel port through its register strobes.
   Assumes the pin model closes the pad loop and the checker is bound. */
`timescale 1ns/1ns
module gpp_port_test;
    reg core_clk, sys_rst, regWrEn, regRdEn, changeNoticeOn;
    reg [3:0] regSel;
    reg [1:0] regOp;
    reg [15:0] regWrData, periphEn, periphOe, periphOut, extDrv, extOe;
    wire [15:0] regRdData, periphIn, pinIn, pinOut, pinOe, analogInSel, pullUpOn, pullDownOn;
    wire changeIrq, sleepWake;
    integer error_cnt, comparisons;
    gpp_port DUT (.core_clk(core_clk), .sys_rst(sys_rst), .regWrEn(regWrEn),
        .regRdEn(regRdEn), .regSel(regSel), .regOp(regOp), .regWrData(regWrData),
        .regRdData(regRdData), .changeNoticeOn(changeNoticeOn), .periphEn(periphEn),
        .periphOe(periphOe), .periphOut(periphOut), .periphIn(periphIn), .pinIn(pinIn),
        .pinOut(pinOut), .pinOe(pinOe), .analogInSel(analogInSel), .pullUpOn(pullUpOn),
        .pullDownOn(pullDownOn), .changeIrq(changeIrq), .sleepWake(sleepWake));
    gpp_pin_model pads (.core_clk(core_clk), .pinOut(pinOut), .pinOe(pinOe),
        .pullUpOn(pullUpOn), .pullDownOn(pullDownOn), .extDrv(extDrv), .extOe(extOe),
        .pinIn(pinIn));
    // Compare and count
    task chk(input [15:0] seen, input [15:0] exp);
        begin
            comparisons = comparisons + 1;
            if (seen !== exp) begin
                error_cnt = error_cnt + 1;
                $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
            end
        end
    endtask
    // Write strobe stays up until a read or idle lowers it
    task wr(input [3:0] s, input [1:0] o, input [15:0] d);
        begin
            regWrEn = 1'b1;
            regSel = s;
            regOp = o;
            regWrData = d;
            @(posedge core_clk);
            #2;
        end
    endtask
    // Read pulse, data checked one cycle after the read edge
    task rd(input [3:0] s, input [1:0] o, input [15:0] e);
        begin
            regWrEn = 1'b0;
            regRdEn = 1'b1;
            regSel = s;
            regOp = o;
            @(posedge core_clk);
            #2 regRdEn = 1'b0;
            @(posedge core_clk);
            #2 chk(regRdData, e);
        end
    endtask
    task idle(input integer n);
        begin
            regWrEn = 1'b0;
            regRdEn = 1'b0;
            repeat (n) @(posedge core_clk);
            #2;
        end
    endtask
    task give_verdict;
        begin
            $display("errors %0d comparisons %0d", error_cnt, comparisons);
            if (error_cnt == 0 && comparisons > 0) begin
                $display("Result: passed");
            end else begin
                $display("Result: failed");
            end
            $finish;
        end
    endtask
    // Clock and watchdog
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    initial begin
        #100000 error_cnt = error_cnt + 1;
        give_verdict;
    end
    // Test sequence
    initial begin
        {sys_rst, regWrEn, regRdEn, changeNoticeOn, regSel, regOp} = 10'h000;
        {regWrData, periphEn, periphOe, periphOut, extDrv} = 80'h0;
        extOe = 16'hffff;
        error_cnt = 0;
        comparisons = 0;
        // Reset rises after time zero so its async edge is never missed
        #2 sys_rst = 1'b1;
        repeat (8) @(posedge core_clk);
        #2 sys_rst = 1'b0;
        chk(analogInSel, 16'hffff);
        chk(pinOe, 16'h0000);
        rd(4'h0, 2'h0, 16'hffff);
        wr(4'h1, 2'h0, 16'h00ff);
        rd(4'h1, 2'h0, 16'h00ff);
        wr(4'h0, 2'h0, 16'h0000);
        idle(1);
        chk(pinOe, 16'hffff);
        chk(pinOut, 16'h00ff);
        wr(4'h4, 2'h0, 16'h0000);
        wr(4'h2, 2'h0, 16'ha5a5);
        rd(4'h1, 2'h0, 16'ha5a5);
        wr(4'h1, 2'h2, 16'h0f00);
        rd(4'h1, 2'h0, 16'hafa5);
        wr(4'h1, 2'h1, 16'h00a5);
        rd(4'h1, 2'h1, 16'h0000);
        rd(4'h1, 2'h0, 16'haf00);
        wr(4'h1, 2'h3, 16'hffff);
        rd(4'h1, 2'h0, 16'h50ff);
        wr(4'h3, 2'h0, 16'h00ff);
        idle(1);
        chk(pinOe, 16'hff00);
        rd(4'h3, 2'h0, 16'h00ff);
        wr(4'h0, 2'h0, 16'hffff);
        extDrv = 16'h1234;
        idle(3);
        rd(4'h2, 2'h0, 16'h1234);
        wr(4'h4, 2'h0, 16'h00ff);
        rd(4'h2, 2'h0, 16'h1200);
        chk(analogInSel, 16'h00ff);
        wr(4'h4, 2'h0, 16'h0000);
        wr(4'h5, 2'h0, 16'h0001);
        changeNoticeOn = 1'b1;
        rd(4'h2, 2'h0, 16'h1234);
        chk({15'h0, sleepWake}, 16'h0000);
        extDrv = 16'h1237;
        #1 chk({15'h0, sleepWake}, 16'h0001);
        idle(3);
        chk({15'h0, changeIrq}, 16'h0001);
        rd(4'h6, 2'h0, 16'h0003);
        wr(4'h6, 2'h0, 16'h0000);
        rd(4'h6, 2'h0, 16'h0003);
        wr(4'h5, 2'h0, 16'h0000);
        idle(1);
        chk({15'h0, changeIrq}, 16'h0000);
        wr(4'h5, 2'h0, 16'h0001);
        rd(4'h2, 2'h0, 16'h1237);
        chk({15'h0, changeIrq}, 16'h0000);
        {periphEn, periphOe, periphOut} = {3{16'h0100}};
        idle(3);
        chk(pinOe, 16'h0100);
        chk(periphIn, 16'h1337);
        periphEn = 16'h0000;
        extOe = 16'h0000;
        wr(4'h7, 2'h0, 16'haaaa);
        wr(4'h8, 2'h0, 16'h5555);
        idle(4);
        rd(4'h2, 2'h0, 16'haaaa);
        wr(4'h8, 2'h2, 16'h00f0);
        wr(4'h7, 2'h1, 16'h00f0);
        wr(4'h8, 2'h3, 16'hffff);
        idle(1);
        chk(pullUpOn, 16'haa0a);
        chk(pullDownOn, 16'haa0a);
        give_verdict;
    end
endmodule // gpp_port_test
